// ===== design/udi_top.sv
`timescale 1ns/1ps
module udi_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [udi_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [udi_pkg::DATA_W-1:0] pwdata_in,
  output logic [udi_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] in_ep_event_in,
  input wire logic [3:1] out_ep_event_in,
  input wire logic attach_detach_in,
  input wire logic sof_in,
  input wire logic bus_reset_in,
  input wire logic resume_in,
  input wire logic suspend_in,
  input wire logic positive_line_level_in,
  input wire logic negative_line_level_in,
  input wire logic resume_request_in,
  output logic irq_out,
  output logic suspend_mode_out
);

  typedef struct packed {
    logic [7:0] in_mask;
    logic [7:0] in_mask_up;
    logic [7:0] out_mask;
    logic [7:0] out_mask_up;
    logic [7:0] bus_mask;
    logic [7:0] captured;
    logic suspend_mode;
    logic irq;
  } udi_top_s;

  udi_top_s cur;
  udi_top_s next_cur;
  udi_reg_if regs ();

  logic [7:0] in_flags;
  logic [7:0] out_flags;
  logic [7:0] bus_flags;
  logic [7:0] in_set;
  logic [7:0] out_set;
  logic [7:0] bus_set;
  logic [7:0] in_clr;
  logic [7:0] out_clr;
  logic [7:0] bus_clr;
  logic [7:0] rd_mux;
  logic bus_read_done;

  udi_apb_slave u_apb (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .bus(regs.slave)
  );

  // event sources
  assign in_set = {4'h0, in_ep_event_in};
  assign out_set = {4'h0, out_ep_event_in, 1'b0};
  always_comb begin
    bus_set = 8'h00;
    bus_set[udi_pkg::BUS_ATTACH] = attach_detach_in;
    bus_set[udi_pkg::BUS_SOF] = sof_in;
    bus_set[udi_pkg::BUS_RESET] = bus_reset_in;
    bus_set[udi_pkg::BUS_RESUME] = resume_in && cur.suspend_mode;
    bus_set[udi_pkg::BUS_SUSPEND] = suspend_in;
  end

  // only bits actually returned to software are cleared; later arrivals stay pending
  assign in_clr = (regs.rd_done && regs.idx == udi_pkg::IDX_IN_EV) ? cur.captured : 8'h00;
  assign out_clr = (regs.rd_done && regs.idx == udi_pkg::IDX_OUT_EV) ? cur.captured : 8'h00;
  assign bus_read_done = regs.rd_done && regs.idx == udi_pkg::IDX_BUS_EV;
  assign bus_clr = bus_read_done ? cur.captured : 8'h00;

  udi_event_bank #(.USED(udi_pkg::IN_EV_USED)) u_in_bank (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(in_set),
    .clr_in(in_clr),
    .flags_out(in_flags)
  );

  udi_event_bank #(.USED(udi_pkg::OUT_EV_USED)) u_out_bank (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(out_set),
    .clr_in(out_clr),
    .flags_out(out_flags)
  );

  udi_event_bank #(.USED(udi_pkg::BUS_EV_USED)) u_bus_bank (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(bus_set),
    .clr_in(bus_clr),
    .flags_out(bus_flags)
  );

  // read mux
  always_comb begin
    rd_mux = 8'h00;
    unique case (regs.idx)
      udi_pkg::IDX_IN_EV: rd_mux = in_flags;
      udi_pkg::IDX_OUT_EV: rd_mux = out_flags;
      udi_pkg::IDX_IN_EV_UP, udi_pkg::IDX_OUT_EV_UP: rd_mux = 8'h00;
      udi_pkg::IDX_BUS_EV: begin
        rd_mux = bus_flags;
        rd_mux[udi_pkg::BUS_DP] = positive_line_level_in;
        rd_mux[udi_pkg::BUS_DM] = negative_line_level_in;
        rd_mux[udi_pkg::BUS_RSVD] = 1'b0;
      end
      udi_pkg::IDX_IN_MASK: rd_mux = cur.in_mask;
      udi_pkg::IDX_IN_MASK_UP: rd_mux = cur.in_mask_up;
      udi_pkg::IDX_OUT_MASK: rd_mux = cur.out_mask;
      udi_pkg::IDX_OUT_MASK_UP: rd_mux = cur.out_mask_up;
      udi_pkg::IDX_BUS_MASK: rd_mux = cur.bus_mask;
      default: rd_mux = 8'h00;
    endcase
  end

  assign regs.rdata = rd_mux;
  assign regs.hit = udi_pkg::idx_is_reg(regs.idx);

  always_comb begin
    next_cur = cur;
    if (regs.rd_setup) begin
      next_cur.captured = rd_mux;
    end
    if (regs.wr_done) begin
      unique case (regs.idx)
        udi_pkg::IDX_IN_MASK: next_cur.in_mask = regs.wdata;
        udi_pkg::IDX_IN_MASK_UP: next_cur.in_mask_up = regs.wdata;
        udi_pkg::IDX_OUT_MASK: next_cur.out_mask = regs.wdata;
        udi_pkg::IDX_OUT_MASK_UP: next_cur.out_mask_up = regs.wdata;
        udi_pkg::IDX_BUS_MASK: next_cur.bus_mask = regs.wdata;
        default: next_cur.in_mask = cur.in_mask;
      endcase
    end
    // entering suspend wins over a clear in the same cycle
    if (suspend_in) begin
      next_cur.suspend_mode = 1'b1;
    end else if (bus_read_done || resume_request_in) begin
      next_cur.suspend_mode = 1'b0;
    end
    // bus mask bits 1 and 0 gate resume and suspend like the others
    next_cur.irq = |(in_flags & cur.in_mask & udi_pkg::IN_EV_USED)
      || |(out_flags & cur.out_mask & udi_pkg::OUT_EV_USED)
      || |(bus_flags & cur.bus_mask & udi_pkg::BUS_EV_USED);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur <= '{in_mask: udi_pkg::RST_IN_MASK,
               in_mask_up: udi_pkg::RST_IN_MASK_UP,
               out_mask: udi_pkg::RST_OUT_MASK,
               out_mask_up: udi_pkg::RST_OUT_MASK_UP,
               bus_mask: udi_pkg::RST_BUS_MASK,
               captured: 8'h00,
               suspend_mode: 1'b0,
               irq: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign irq_out = cur.irq;
  assign suspend_mode_out = cur.suspend_mode;

  a_in_clear_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    regs.rd_done && regs.idx == udi_pkg::IDX_IN_EV && in_ep_event_in == 4'h0
    |=> (in_flags & $past(cur.captured)) == 8'h00)
    else $error("in events not cleared by read");

  a_out_reserved_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    regs.rd_done && regs.idx == udi_pkg::IDX_OUT_EV && out_ep_event_in == 3'h0
    |=> out_flags == ($past(out_flags) & ~$past(cur.captured)) && !out_flags[0])
    else $error("out events wrong after read");

  a_live_lines: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    regs.rd_setup && regs.idx == udi_pkg::IDX_BUS_EV
    |=> prdata_out[7:5] == {$past(positive_line_level_in), $past(negative_line_level_in), 1'b0})
    else $error("line levels not reported");

  a_attach_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    attach_detach_in |=> bus_flags[udi_pkg::BUS_ATTACH])
    else $error("attach event not flagged");

  a_sof_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sof_in |=> bus_flags[udi_pkg::BUS_SOF])
    else $error("frame start not flagged");

  a_reset_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    bus_reset_in |=> bus_flags[udi_pkg::BUS_RESET])
    else $error("bus reset not flagged");

  a_resume_gated: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !bus_flags[udi_pkg::BUS_RESUME] |=> bus_flags[udi_pkg::BUS_RESUME] == $past(resume_in && cur.suspend_mode))
    else $error("resume flag wrong for suspend state");

  a_suspend_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    suspend_in |=> bus_flags[udi_pkg::BUS_SUSPEND] && suspend_mode_out)
    else $error("suspend not flagged");

  a_in_mask_reset: assert property (@(posedge clk_in)
    $past(sys_rst_in) && !sys_rst_in |-> cur.in_mask == 8'hff)
    else $error("in mask reset value wrong");

  a_out_mask_reset: assert property (@(posedge clk_in)
    $past(sys_rst_in) && !sys_rst_in |-> cur.out_mask == 8'hfe)
    else $error("out mask reset value wrong");

  a_bus_mask_reset: assert property (@(posedge clk_in)
    $past(sys_rst_in) && !sys_rst_in |-> cur.bus_mask == 8'h06 && cur.out_mask_up == 8'hff)
    else $error("bus mask reset value wrong");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    regs.rd_setup && (regs.idx == udi_pkg::IDX_IN_EV_UP || regs.idx == udi_pkg::IDX_OUT_EV_UP)
    |=> prdata_out == 32'h00000000 && !pslverr_out)
    else $error("reserved event register not zero");

  a_suspend_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    bus_flags[udi_pkg::BUS_SUSPEND] && cur.bus_mask[udi_pkg::BUS_SUSPEND] |=> irq_out)
    else $error("enabled suspend gives no interrupt");

  a_suspend_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (bus_read_done || resume_request_in) && !suspend_in |=> !suspend_mode_out)
    else $error("suspend mode not cleared");

  a_irq_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (in_flags & cur.in_mask) == 8'h00 && (out_flags & cur.out_mask) == 8'h00
    && (bus_flags & cur.bus_mask) == 8'h00 |=> !irq_out)
    else $error("interrupt without enabled event");

endmodule // udi_top

// ===== include/udi_pkg.sv
package udi_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_IN_EV = 4'h2;
  localparam logic [3:0] IDX_IN_EV_UP = 4'h3;
  localparam logic [3:0] IDX_OUT_EV = 4'h4;
  localparam logic [3:0] IDX_OUT_EV_UP = 4'h5;
  localparam logic [3:0] IDX_BUS_EV = 4'h6;
  localparam logic [3:0] IDX_IN_MASK = 4'h7;
  localparam logic [3:0] IDX_IN_MASK_UP = 4'h8;
  localparam logic [3:0] IDX_OUT_MASK = 4'h9;
  localparam logic [3:0] IDX_OUT_MASK_UP = 4'ha;
  localparam logic [3:0] IDX_BUS_MASK = 4'hb;

  // reset values
  localparam logic [7:0] RST_EVENTS = 8'h00;
  localparam logic [7:0] RST_IN_MASK = 8'hff;
  localparam logic [7:0] RST_IN_MASK_UP = 8'hff;
  localparam logic [7:0] RST_OUT_MASK = 8'hfe;
  localparam logic [7:0] RST_OUT_MASK_UP = 8'hff;
  localparam logic [7:0] RST_BUS_MASK = 8'h06;

  // implemented event bits of each event register
  localparam logic [7:0] IN_EV_USED = 8'h0f;
  localparam logic [7:0] OUT_EV_USED = 8'h0e;
  localparam logic [7:0] BUS_EV_USED = 8'h1f;

  // bus event register fields
  localparam int BUS_DP = 7;
  localparam int BUS_DM = 6;
  localparam int BUS_RSVD = 5;
  localparam int BUS_ATTACH = 4;
  localparam int BUS_SOF = 3;
  localparam int BUS_RESET = 2;
  localparam int BUS_RESUME = 1;
  localparam int BUS_SUSPEND = 0;

  // out endpoint bits 1 to 3
  localparam int OUT_EP_LO = 1;
  localparam int OUT_EP_HI = 3;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [3:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  function automatic logic idx_is_reg(input logic [3:0] idx);
    return (idx >= IDX_IN_EV) && (idx <= IDX_BUS_MASK);
  endfunction

endpackage

// ===== include/udi_reg_if.sv
`timescale 1ns/1ps
interface udi_reg_if;
  logic [3:0] idx;
  logic rd_setup;
  logic rd_done;
  logic wr_done;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport slave (output idx, rd_setup, rd_done, wr_done, wdata, input rdata, hit);
  modport regs (input idx, rd_setup, rd_done, wr_done, wdata, output rdata, hit);
endinterface

// ===== design/udi_event_bank.sv
`timescale 1ns/1ps
module udi_event_bank #(
  parameter logic [7:0] USED = 8'hff
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] set_in,
  input wire logic [7:0] clr_in,
  output logic [7:0] flags_out
);

  typedef struct packed {
    logic [7:0] flags;
  } udi_bank_s;

  udi_bank_s cur;
  udi_bank_s next_cur;

  // a set arriving with the clear survives so no event is lost
  always_comb begin
    next_cur = cur;
    next_cur.flags = ((cur.flags & ~clr_in) | set_in) & USED;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur <= '{flags: udi_pkg::RST_EVENTS};
    end else begin
      cur <= next_cur;
    end
  end

  assign flags_out = cur.flags;

  a_set_beats_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (set_in & USED) != 8'h00 |=> (flags_out & $past(set_in & USED)) == $past(set_in & USED))
    else $error("event set lost against clear");

  a_unused_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (flags_out & ~USED) == 8'h00)
    else $error("unimplemented event bit set");

endmodule // udi_event_bank

// ===== design/udi_apb_slave.sv
`timescale 1ns/1ps
module udi_apb_slave (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [udi_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [udi_pkg::DATA_W-1:0] pwdata_in,
  output logic [udi_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  udi_reg_if.slave bus
);

  typedef struct packed {
    logic ready;
    logic err;
    logic [udi_pkg::DATA_W-1:0] rdata;
  } udi_apb_s;

  udi_apb_s cur;
  udi_apb_s next_cur;
  logic setup;
  logic done;
  logic addr_ok;

  assign setup = psel_in && !penable_in;
  assign done = psel_in && penable_in && cur.ready;
  assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[7:6] == 2'h0);

  assign bus.idx = paddr_in[5:2];
  assign bus.wdata = pwdata_in[7:0];
  assign bus.rd_setup = setup && !pwrite_in && addr_ok;
  assign bus.rd_done = done && !pwrite_in && !cur.err;
  assign bus.wr_done = done && pwrite_in && !cur.err;

  // data and answer are prepared in the setup cycle so the access phase needs no wait
  always_comb begin
    next_cur = cur;
    next_cur.ready = 1'b0;
    if (setup) begin
      next_cur.ready = 1'b1;
      next_cur.err = !(addr_ok && bus.hit);
      next_cur.rdata = '0;
      if (!pwrite_in && addr_ok && bus.hit) begin
        next_cur.rdata = {24'h000000, bus.rdata};
      end
    end else if (done) begin
      next_cur.err = 1'b0;
      next_cur.rdata = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur <= '{ready: 1'b0, err: 1'b0, rdata: 32'h00000000};
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata_out = cur.rdata;
  assign pready_out = cur.ready;
  assign pslverr_out = cur.err;

  a_ready_after_setup: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("pready not one cycle after setup");

endmodule // udi_apb_slave

// ===== testbench/udi_host_model.sv
`timescale 1ns/1ps
// stands in for the host and the line receiver; every event is a one-cycle pulse
module udi_host_model (
  input wire logic clk_in,
  input wire logic [11:0] ev_req_in,
  input wire logic [1:0] line_req_in,
  output logic [3:0] in_ep_event_out,
  output logic [3:1] out_ep_event_out,
  output logic attach_detach_out,
  output logic sof_out,
  output logic bus_reset_out,
  output logic resume_out,
  output logic suspend_out,
  output logic pos_line_out,
  output logic neg_line_out
);
  logic [11:0] ev;
  logic pos_line;
  logic neg_line;
  // a request shows on the line one clock later, like a receiver stage would
  always_ff @(posedge clk_in) begin
    ev <= ev_req_in;
    pos_line <= line_req_in[1];
    neg_line <= line_req_in[0];
  end
  assign in_ep_event_out = ev[3:0];
  assign out_ep_event_out = ev[6:4];
  assign attach_detach_out = ev[7];
  assign sof_out = ev[8];
  assign bus_reset_out = ev[9];
  assign resume_out = ev[10];
  assign suspend_out = ev[11];
  assign pos_line_out = pos_line;
  assign neg_line_out = neg_line;
endmodule // udi_host_model

// ===== testbench/test_usb_device_interrupt_flags.sv
`timescale 1ns/1ps
module test_usb_device_interrupt_flags;
  logic clk_in;
  logic sys_rst_in;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [3:0] in_ev;
  logic [3:1] out_ev;
  logic att, sof, brst, res, susp, pos_line, neg_line;
  logic rreq;
  logic [11:0] ev_req;
  logic [1:0] line_req;
  logic irq_out;
  logic suspend_mode_out;
  logic [31:0] rd;
  logic er;
  int errors;
  int checks_done;

  udi_host_model host_u (.clk_in(clk_in), .ev_req_in(ev_req), .line_req_in(line_req),
    .in_ep_event_out(in_ev), .out_ep_event_out(out_ev),
    .attach_detach_out(att), .sof_out(sof), .bus_reset_out(brst), .resume_out(res),
    .suspend_out(susp), .pos_line_out(pos_line), .neg_line_out(neg_line));

  udi_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .in_ep_event_in(in_ev),
    .out_ep_event_in(out_ev), .attach_detach_in(att), .sof_in(sof), .bus_reset_in(brst),
    .resume_in(res), .suspend_in(susp), .positive_line_level_in(pos_line),
    .negative_line_level_in(neg_line), .resume_request_in(rreq), .irq_out(irq_out),
    .suspend_mode_out(suspend_mode_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // holds the request until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_in);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    chk({31'h0, pready_out}, 32'h1, "ready");
    rd = prdata_out;
    er = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    chk(rd, e, "read data");
    chk({31'h0, er}, {31'h0, ee}, "slave error");
  endtask

  task automatic irqc(input logic e);
    repeat (2) @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, {31'h0, e}, "interrupt");
  endtask

  task automatic smc(input logic e);
    @(posedge clk_in);
    #1;
    chk({31'h0, suspend_mode_out}, {31'h0, e}, "suspend mode");
  endtask

  // returns after the edge at which the design has taken the event
  task automatic pulse(input logic [11:0] m);
    @(posedge clk_in);
    ev_req <= m;
    @(posedge clk_in);
    ev_req <= 12'h000;
    @(posedge clk_in);
  endtask

  task automatic set_lines(input logic p, input logic n);
    @(posedge clk_in);
    line_req <= {p, n};
    @(posedge clk_in);
  endtask

  initial begin
    repeat (3000) @(posedge clk_in);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    sys_rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rreq = 1'b0;
    ev_req = 12'h000;
    line_req = 2'b10;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rdc(8'h1c, 32'hff, 1'b0);
    rdc(8'h20, 32'hff, 1'b0);
    rdc(8'h24, 32'hfe, 1'b0);
    rdc(8'h28, 32'hff, 1'b0);
    rdc(8'h2c, 32'h06, 1'b0);
    rdc(8'h0c, 32'h00, 1'b0);
    rdc(8'h14, 32'h00, 1'b0);
    rdc(8'h30, 32'h00, 1'b1);
    rdc(8'h09, 32'h00, 1'b1);
    $display("test reset values done");
    pulse(12'h00f);
    irqc(1'b1);
    rdc(8'h08, 32'h0f, 1'b0);
    irqc(1'b0);
    rdc(8'h08, 32'h00, 1'b0);
    apb(1'b1, 8'h1c, 8'h00);
    pulse(12'h001);
    irqc(1'b0);
    apb(1'b1, 8'h1c, 8'h01);
    irqc(1'b1);
    rdc(8'h1c, 32'h01, 1'b0);
    rdc(8'h08, 32'h01, 1'b0);
    $display("test in endpoint events done");
    pulse(12'h070);
    irqc(1'b1);
    rdc(8'h10, 32'h0e, 1'b0);
    rdc(8'h10, 32'h00, 1'b0);
    $display("test out endpoint events done");
    pulse(12'h080);
    rdc(8'h18, 32'h90, 1'b0);
    pulse(12'h100);
    irqc(1'b0);
    apb(1'b1, 8'h2c, 8'h08);
    irqc(1'b1);
    rdc(8'h18, 32'h88, 1'b0);
    irqc(1'b0);
    pulse(12'h200);
    rdc(8'h18, 32'h84, 1'b0);
    pulse(12'h400);
    rdc(8'h18, 32'h80, 1'b0);
    set_lines(1'b0, 1'b1);
    rdc(8'h18, 32'h40, 1'b0);
    set_lines(1'b1, 1'b0);
    rdc(8'h18, 32'h80, 1'b0);
    $display("test bus events done");
    apb(1'b1, 8'h2c, 8'h01);
    pulse(12'h800);
    smc(1'b1);
    irqc(1'b1);
    pulse(12'h400);
    rdc(8'h18, 32'h83, 1'b0);
    smc(1'b0);
    pulse(12'h800);
    smc(1'b1);
    @(posedge clk_in);
    rreq <= 1'b1;
    @(posedge clk_in);
    rreq <= 1'b0;
    smc(1'b0);
    apb(1'b1, 8'h2c, 8'h02);
    pulse(12'h400);
    irqc(1'b0);
    rdc(8'h18, 32'h81, 1'b0);
    $display("test suspend and resume done");
    apb(1'b1, 8'h24, 8'h00);
    rdc(8'h24, 32'h00, 1'b0);
    pulse(12'h80f);
    smc(1'b1);
    irqc(1'b1);
    // a second reset in mid-run must restore masks and drop pending events
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    smc(1'b0);
    irqc(1'b0);
    rdc(8'h24, 32'hfe, 1'b0);
    rdc(8'h1c, 32'hff, 1'b0);
    rdc(8'h2c, 32'h06, 1'b0);
    rdc(8'h08, 32'h00, 1'b0);
    rdc(8'h18, 32'h80, 1'b0);
    $display("test reset in mid-run done");
    complete_run();
  end
endmodule // test_usb_device_interrupt_flags
